//--- odp_top.sv
/*
 * Byte DMA engine and host memory port in front of on-chip memory.
 * Assumes the core owns on-chip memory and grants one cycle per
 * mem_o.req; mem_rdata is valid within the same cycle that a read mem_o.req is high.
 */
`timescale 1ns/10ps
module odp_top
    import odp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        dma_sel_cfg,
    input  wire logic        boot_sel_cfg,
    input  wire logic        host_mem_mode,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [13:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata_r,
    input  wire logic        core_ext_req,
    output odp_mem_t         mem_o,
    input  wire logic [23:0] mem_rdata,
    output odp_bm_t          bm_o,
    input  wire logic [7:0]  bm_data_i,
    output logic             core_halt_r,
    output logic             core_restart_r,
    output logic             byte_dma_engine_irq_r,
    input  wire logic        host_port_select_n,
    input  wire logic        host_address_latch,
    input  wire logic        host_read_strobe_n,
    input  wire logic        host_write_strobe_n,
    input  wire logic [15:0] host_muxed_bus_i,
    output logic      [15:0] host_muxed_bus_o_r,
    output logic             host_muxed_bus_oe_r,
    output logic             host_port_acknowledge_n_r
);

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_FETCH_W, ST_BGO,
        ST_BYTE, ST_STORE, ST_HP_ACC, ST_HP_RDW
    } odp_state_t;

    odp_state_t          state_r;
    logic                init_r;
    logic                host_path_r;
    logic [15:0]         sysctl_r;
    odp_fmt_t            fmt_r;
    logic                dir_r;
    logic                bcr_r;
    logic [OVL_W-1:0]    bovl_r;
    logic [13:0]         internal_start_address_r;
    logic [OFS_W-1:0]    byte_external_start_offset_r;
    logic [PAGE_W-1:0]   page_r;
    logic [CNT_W-1:0]    cnt_r;
    logic [23:0]         acc_r;
    logic [1:0]          bidx_r;
    logic [WS_W-1:0]     wait_r;
    logic [13:0]         hp_addr_r;
    logic                hp_pm_r;
    logic [HP_OVL_W-1:0] hp_ovl_r;
    logic                hp_we_r;
    logic                hp_half_r;
    logic [15:0]         hp_hi_r;
    logic [7:0]          hp_lo_r;
    logic [15:0]         hp_data_r;
    logic                hp_inc_r;
    logic [3:0]          hs_lvl;
    logic [3:0]          hs_rise;
    logic                hp_sel;
    logic                hp_go;
    logic                hp_blk;
    logic [1:0]          nbytes;
    logic                last_word;
    logic [7:0]          out_byte;
    logic [23:0]         store_word;

    // ****************************************
    // host strobe synchroniser
    // ****************************************
    odp_edge_sync #(
        .W (4)
    ) u_hsync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d_i     ({~host_port_select_n, ~host_address_latch,
                   ~host_read_strobe_n, ~host_write_strobe_n}),
        .lvl_o   (hs_lvl),
        .rise_o  (hs_rise)
    );

    assign hp_sel = hs_lvl[3];
    assign hp_go  = hp_sel & (hs_rise[1] | hs_rise[0]);

    // ****************************************
    // word formatting
    // ****************************************
    always_comb begin
        case (fmt_r)
            FMT_PM24: nbytes = 2'h3;
            FMT_DM16: nbytes = 2'h2;
            default:  nbytes = 2'h1;
        endcase
    end

    always_comb begin
        out_byte = hp_data_r[7:0];
        case (fmt_r)
            FMT_PM24: begin
                case (bidx_r)
                    2'h0:    out_byte = acc_r[23:16];
                    2'h1:    out_byte = acc_r[15:8];
                    default: out_byte = acc_r[7:0];
                endcase
            end
            FMT_DM16:  out_byte = (bidx_r == 2'h0) ? acc_r[15:8] : acc_r[7:0];
            FMT_DM8HI: out_byte = acc_r[15:8];
            default:   out_byte = acc_r[7:0];
        endcase
    end

    // unused bits of the narrow formats go to memory as zero
    always_comb begin
        case (fmt_r)
            FMT_PM24:  store_word = acc_r;
            FMT_DM16:  store_word = {8'h00, acc_r[15:0]};
            FMT_DM8HI: store_word = {8'h00, acc_r[7:0], 8'h00};
            default:   store_word = {16'h0000, acc_r[7:0]};
        endcase
    end

    assign last_word = (cnt_r == 14'h0001);
    // memory-mapped control registers sit at the top of data memory
    assign hp_blk = hp_we_r & ~hp_pm_r & (hp_addr_r >= A_CTL_BASE);

    // ****************************************
    // byte DMA engine, host access sequencing
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r        <= ST_IDLE;
            init_r         <= 1'b0;
            host_path_r    <= 1'b0;
            sysctl_r       <= '0;
            fmt_r          <= FMT_PM24;
            dir_r          <= 1'b0;
            bcr_r          <= 1'b0;
            bovl_r         <= '0;
            internal_start_address_r         <= '0;
            byte_external_start_offset_r         <= '0;
            page_r         <= '0;
            cnt_r          <= '0;
            acc_r          <= '0;
            bidx_r         <= '0;
            wait_r         <= '0;
            mem_o          <= '0;
            bm_o           <= '{rd_n: 1'b1, wr_n: 1'b1, bms_n: 1'b1, default: '0};
            core_halt_r    <= 1'b0;
            core_restart_r <= 1'b0;
            byte_dma_engine_irq_r     <= 1'b0;
            hp_we_r        <= 1'b0;
            hp_half_r      <= 1'b0;
            hp_hi_r        <= '0;
            hp_lo_r        <= '0;
            hp_data_r      <= '0;
            hp_inc_r       <= 1'b0;
            host_muxed_bus_o_r <= '0;
        end else begin
            mem_o.req      <= 1'b0;
            core_restart_r <= 1'b0;
            byte_dma_engine_irq_r     <= 1'b0;
            hp_inc_r       <= 1'b0;
            bm_o.bms_n     <= 1'b1;
            if (sysctl_r[SC_BMS_DIS]) begin
                bm_o.bms_n <= 1'b1;
            end else if ((state_r == ST_BGO && !core_ext_req) || (state_r == ST_BYTE && wait_r != '0)) begin
                bm_o.bms_n <= 1'b0;
            end
            // mode straps are caught on the first edge after release
            if (!init_r) begin
                init_r      <= 1'b1;
                host_path_r <= dma_sel_cfg;
                if (!dma_sel_cfg && !boot_sel_cfg) begin
                    cnt_r <= BOOT_COUNT;
                    bcr_r <= 1'b1;
                end
            end
            if (reg_wr) begin
                case (reg_addr)
                    A_SYSCTL: sysctl_r <= reg_wdata;
                    A_BCTL: begin
                        fmt_r  <= odp_fmt_t'(reg_wdata[BC_FMT_LO +: 2]);
                        dir_r  <= reg_wdata[BC_DIR];
                        bcr_r  <= reg_wdata[BC_BCR];
                        bovl_r <= reg_wdata[BC_OVL_LO +: OVL_W];
                    end
                    A_INTERNAL_START_ADDRESS:  internal_start_address_r <= reg_wdata[13:0];
                    A_BYTE_EXTERNAL_START_OFFSET:  byte_external_start_offset_r <= reg_wdata[OFS_W-1:0];
                    A_BPAGE: page_r <= reg_wdata[PAGE_W-1:0];
                    A_BCNT:  cnt_r  <= reg_wdata[CNT_W-1:0];
                    default: ;
                endcase
            end
            case (state_r)
                ST_IDLE: begin
                    bidx_r <= '0;
                    if (host_path_r && hp_go) begin
                        hp_we_r   <= hs_rise[0];
                        hp_data_r <= host_muxed_bus_i;
                        state_r   <= ST_HP_ACC;
                    end else if (init_r && !host_path_r && cnt_r != '0) begin
                        core_halt_r <= bcr_r;
                        state_r     <= dir_r ? ST_FETCH : ST_BGO;
                    end
                end
                ST_FETCH: begin
                    mem_o <= '{req: 1'b1, we: 1'b0, pm: (fmt_r == FMT_PM24),
                               ovl: {4'h0, bovl_r}, addr: internal_start_address_r, wdata: 24'h000000};
                    state_r <= ST_FETCH_W;
                end
                ST_FETCH_W: begin
                    acc_r   <= mem_rdata;
                    state_r <= ST_BGO;
                end
                ST_BGO: begin
                    // the core's own external cycle always goes first
                    if (!core_ext_req) begin
                        bm_o.rd_n  <= dir_r;
                        bm_o.wr_n  <= ~dir_r;
                        bm_o.oe    <= dir_r;
                        bm_o.wdata <= out_byte;
                        bm_o.page  <= host_mem_mode ? 8'h00 : page_r;
                        bm_o.addr  <= host_mem_mode ? {13'h0000, byte_external_start_offset_r[0]} : byte_external_start_offset_r;
                        wait_r     <= sysctl_r[SC_WS_LO +: WS_W];
                        state_r    <= ST_BYTE;
                    end
                end
                ST_BYTE: begin
                    if (wait_r != '0) begin
                        wait_r <= wait_r - 3'h1;
                    end else begin
                        bm_o.rd_n <= 1'b1;
                        bm_o.wr_n <= 1'b1;
                        bm_o.oe   <= 1'b0;
                        if (!dir_r) begin
                            acc_r <= {acc_r[15:0], bm_data_i};
                        end
                        {page_r, byte_external_start_offset_r} <= {page_r, byte_external_start_offset_r} + 22'h000001;
                        bidx_r <= bidx_r + 2'h1;
                        state_r <= (bidx_r == nbytes - 2'h1) ? ST_STORE : ST_BGO;
                    end
                end
                ST_STORE: begin
                    if (!dir_r) begin
                        mem_o <= '{req: 1'b1, we: 1'b1, pm: (fmt_r == FMT_PM24),
                                   ovl: {4'h0, bovl_r}, addr: internal_start_address_r, wdata: store_word};
                    end
                    bidx_r <= '0;
                    acc_r  <= '0;
                    cnt_r  <= cnt_r - 14'h0001;
                    internal_start_address_r <= internal_start_address_r + 14'h0001;
                    if (last_word) begin
                        byte_dma_engine_irq_r     <= 1'b1;
                        core_halt_r    <= 1'b0;
                        core_restart_r <= bcr_r;
                        state_r        <= ST_IDLE;
                    end else begin
                        state_r <= dir_r ? ST_FETCH : ST_BGO;
                    end
                end
                ST_HP_ACC: begin
                    // 24-bit words take two host words: upper 16, then low 8
                    state_r <= ST_IDLE;
                    if (hp_pm_r && !hp_half_r && hp_we_r) begin
                        hp_hi_r   <= hp_data_r;
                        hp_half_r <= 1'b1;
                    end else if (hp_pm_r && hp_half_r && !hp_we_r) begin
                        host_muxed_bus_o_r <= {8'h00, hp_lo_r};
                        hp_half_r          <= 1'b0;
                        hp_inc_r           <= 1'b1;
                    end else begin
                        mem_o <= '{req: !hp_blk, we: hp_we_r, pm: hp_pm_r, ovl: hp_ovl_r,
                                   addr: hp_addr_r,
                                   wdata: hp_pm_r ? {hp_hi_r, hp_data_r[7:0]}
                                                  : {8'h00, hp_data_r}};
                        if (hp_we_r) begin
                            hp_half_r <= 1'b0;
                            hp_inc_r  <= 1'b1;
                        end else begin
                            state_r <= ST_HP_RDW;
                        end
                    end
                end
                ST_HP_RDW: begin
                    if (hp_pm_r) begin
                        host_muxed_bus_o_r <= mem_rdata[23:8];
                        hp_lo_r            <= mem_rdata[7:0];
                        hp_half_r          <= 1'b1;
                    end else begin
                        host_muxed_bus_o_r <= mem_rdata[15:0];
                        hp_inc_r           <= 1'b1;
                    end
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // host address and overlay latch
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hp_addr_r <= '0;
            hp_pm_r   <= 1'b0;
            hp_ovl_r  <= '0;
        end else begin
            if (reg_wr && reg_addr == A_HP_ADDR) begin
                hp_addr_r <= reg_wdata[13:0];
                hp_pm_r   <= ~reg_wdata[HP_PM_BIT];
            end
            if (reg_wr && reg_addr == A_HP_OVL) begin
                hp_ovl_r <= reg_wdata[HP_OVL_W-1:0];
            end
            if (hp_inc_r) begin
                hp_addr_r <= hp_addr_r + 14'h0001;
            end
            if (host_path_r && hp_sel && hs_rise[2]) begin
                if (host_muxed_bus_i[HP_OVL_BIT]) begin
                    hp_ovl_r <= host_muxed_bus_i[HP_OVL_W-1:0];
                end else begin
                    hp_addr_r <= host_muxed_bus_i[13:0];
                    hp_pm_r   <= ~host_muxed_bus_i[HP_PM_BIT];
                end
            end
        end
    end

    // ****************************************
    // host handshake and core register reads
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            host_port_acknowledge_n_r <= 1'b1;
            host_muxed_bus_oe_r       <= 1'b0;
            reg_rdata_r               <= '0;
        end else begin
            host_port_acknowledge_n_r <= !(host_path_r && state_r == ST_IDLE
                                           && !hp_go && !hp_inc_r);
            host_muxed_bus_oe_r <= host_path_r && hp_sel && hs_lvl[1];
            reg_rdata_r <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    A_SYSCTL: reg_rdata_r <= sysctl_r;
                    A_BCTL:   reg_rdata_r <= {8'h00, bovl_r, bcr_r, dir_r, fmt_r};
                    A_INTERNAL_START_ADDRESS:   reg_rdata_r <= {2'h0, internal_start_address_r};
                    A_BYTE_EXTERNAL_START_OFFSET:   reg_rdata_r <= {2'h0, byte_external_start_offset_r};
                    A_BPAGE:  reg_rdata_r <= {8'h00, page_r};
                    A_BCNT:   reg_rdata_r <= {2'h0, cnt_r};
                    A_HP_ADDR: reg_rdata_r <= {1'b0, ~hp_pm_r, hp_addr_r};
                    A_HP_OVL: reg_rdata_r <= {8'h00, hp_ovl_r};
                    default:  reg_rdata_r <= '0;
                endcase
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence hp_strobe_s;
        state_r == ST_IDLE && host_path_r && hp_go;
    endsequence
    sequence hp_access_s;
        state_r == ST_HP_ACC ##1 state_r != ST_HP_ACC;
    endsequence

    bms_suppress_a: assert property (sysctl_r[SC_BMS_DIS] |=> bm_o.bms_n)
        else $error("boot select driven while disabled");
    mem_one_cycle_a: assert property (mem_o.req |=> !mem_o.req)
        else $error("memory steal longer than one cycle");
    bus_priority_a: assert property (state_r == ST_BGO && core_ext_req
                                     |=> bm_o.rd_n && bm_o.wr_n)
        else $error("byte strobe during core external access");
    irq_at_zero_a: assert property (byte_dma_engine_irq_r |-> cnt_r == '0 && state_r == ST_IDLE)
        else $error("interrupt without count at zero");
    zero_write_a: assert property (state_r == ST_IDLE && reg_wr && reg_addr == A_BCNT
                                   && reg_wdata == 16'h0000 && !host_path_r
                                   |=> state_r == ST_IDLE ##1 !byte_dma_engine_irq_r)
        else $error("zero count started a transfer");
    ctl_protect_a: assert property (host_path_r && mem_o.req && mem_o.we && !mem_o.pm
                                    |-> mem_o.addr < A_CTL_BASE)
        else $error("host wrote a control register");
    host_access_a: assert property (hp_strobe_s |=> hp_access_s)
        else $error("host access not performed in one cycle");
    addr_incr_a: assert property (hp_inc_r && !(hp_sel && hs_rise[2])
                                  |=> hp_addr_r == $past(hp_addr_r) + 14'h0001)
        else $error("host address not incremented");
    restart_a: assert property (state_r == ST_STORE && last_word && bcr_r
                                |=> core_restart_r && !core_halt_r)
        else $error("context reset restart missing");

endmodule : odp_top

//--- odp_pkg.sv
/*
 * Constants, register map and carrier types for the on-chip memory
 * DMA ports (byte DMA engine and host memory port).
 * Assumes a 16-bit core data-memory register port and one clock.
 */
package odp_pkg;

    // ****************************************
    // register offsets (data memory)
    // ****************************************
    localparam logic [13:0] A_HP_ADDR  = 14'h3FE0;
    localparam logic [13:0] A_INTERNAL_START_ADDRESS     = 14'h3FE2;
    localparam logic [13:0] A_BCTL     = 14'h3FE3;
    localparam logic [13:0] A_BYTE_EXTERNAL_START_OFFSET     = 14'h3FE4;
    localparam logic [13:0] A_BPAGE    = 14'h3FE5;
    localparam logic [13:0] A_BCNT     = 14'h3FE6;
    localparam logic [13:0] A_HP_OVL   = 14'h3FE7;
    localparam logic [13:0] A_SYSCTL   = 14'h3FFF;
    localparam logic [13:0] A_CTL_BASE = 14'h3FE0;

    // ****************************************
    // fields and widths
    // ****************************************
    localparam int SC_BMS_DIS = 3;
    localparam int SC_WS_LO   = 12;
    localparam int WS_W       = 3;
    localparam int BC_FMT_LO  = 0;
    localparam int BC_DIR     = 2;
    localparam int BC_BCR     = 3;
    localparam int BC_OVL_LO  = 4;
    localparam int OVL_W      = 4;
    localparam int OFS_W      = 14;
    localparam int PAGE_W     = 8;
    localparam int CNT_W      = 14;
    localparam int HP_OVL_BIT = 15;
    localparam int HP_PM_BIT  = 14;
    localparam int HP_OVL_W   = 8;

    localparam logic [CNT_W-1:0] BOOT_COUNT = 14'h0020;

    typedef enum logic [1:0] {
        FMT_PM24  = 2'h0,
        FMT_DM16  = 2'h1,
        FMT_DM8HI = 2'h2,
        FMT_DM8LO = 2'h3
    } odp_fmt_t;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        req;
        logic        we;
        logic        pm;
        logic [7:0]  ovl;
        logic [13:0] addr;
        logic [23:0] wdata;
    } odp_mem_t;

    typedef struct packed {
        logic        rd_n;
        logic        wr_n;
        logic        oe;
        logic        bms_n;
        logic [7:0]  page;
        logic [13:0] addr;
        logic [7:0]  wdata;
    } odp_bm_t;

endpackage : odp_pkg

//--- odp_edge_sync.sv
/*
 * Synchroniser with rising-edge pulse for a group of host strobes.
 * Assumes d_i is active high; every bit is synchronised alone.
 */
`timescale 1ns/10ps
module odp_edge_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] lvl_o,
    output logic      [W-1:0] rise_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_r   <= '0;
            s2_r   <= '0;
            lvl_o  <= '0;
            rise_o <= '0;
        end else begin
            s1_r   <= d_i;
            s2_r   <= s1_r;
            lvl_o  <= s2_r;
            rise_o <= s2_r & ~lvl_o;
        end
    end
endmodule : odp_edge_sync

//--- odp_mem_model.sv
/*
 * Far-side model: byte-wide external memory plus on-chip memory read port.
 * Assumes odp_top registered strobes and one-cycle mem_o.req pulses.
 */
`timescale 1ns/10ps
module odp_mem_model
    import odp_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire odp_bm_t     bm_o,
    input  wire odp_mem_t    mem_o,
    output logic      [7:0]  bm_data_i,
    output logic      [23:0] mem_rdata
);
    // released bus shows inverted offset so stale bytes never match, except on page FF
    assign bm_data_i = bm_o.rd_n ? ~bm_o.addr[7:0] : bm_o.addr[7:0] ^ bm_o.page;

    // opposite edge: data settles inside the request cycle, as the engine samples it
    always_ff @(negedge clk_sys) begin
        mem_rdata <= {10'h000, mem_o.addr};
    end
endmodule : odp_mem_model

//--- tb_odp_top.sv
/*
 * Self-checking bench for odp_top byte DMA path and boot.
 * Assumes odp_mem_model as far side; host port driven by task hp.
 */
`timescale 1ns/10ps
module tb_odp_top;
    import odp_pkg::*;
    logic        clk_sys = 0, arst_n = 0, boot_sel_cfg = 1, dma_sel_cfg = 0;
    logic        host_mem_mode = 0, core_ext_req = 0, reg_wr = 0, reg_rd = 0;
    logic [13:0] reg_addr = '0, got_a;
    logic [15:0] reg_wdata = '0, reg_rdata_r, v;
    logic [23:0] mem_rdata, got_w;
    logic [7:0]  bm_data_i;
    logic        core_halt_r, core_restart_r, byte_dma_engine_irq_r, got_pm, bms_low = 0;
    odp_mem_t    mem_o;
    odp_bm_t     bm_o;
    logic        hsel_n = 1, hal = 1, hrd_n = 1, hwr_n = 1, hoe, ack_n;
    logic [15:0] hbus = '0, hout, got_b;
    logic [16:0] hr, hr2;
    logic [21:0] got_e;
    int          nirq = 0, nrst = 0, cyc = 0, n_fail = 0, comparisons = 0;
    logic [23:0] exp_w [4] = '{24'h101112, 24'h001011, 24'h001000, 24'h000010};

    odp_top odp_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .dma_sel_cfg(dma_sel_cfg),
        .boot_sel_cfg(boot_sel_cfg), .host_mem_mode(host_mem_mode), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .core_ext_req(core_ext_req), .mem_o(mem_o), .mem_rdata(mem_rdata), .bm_o(bm_o),
        .bm_data_i(bm_data_i), .core_halt_r(core_halt_r), .core_restart_r(core_restart_r),
        .byte_dma_engine_irq_r(byte_dma_engine_irq_r), .host_port_select_n(hsel_n), .host_address_latch(hal),
        .host_read_strobe_n(hrd_n), .host_write_strobe_n(hwr_n), .host_muxed_bus_i(hbus),
        .host_muxed_bus_o_r(hout), .host_muxed_bus_oe_r(hoe), .host_port_acknowledge_n_r(ack_n));
    odp_mem_model odp_mem_model_inst (.clk_sys(clk_sys), .bm_o(bm_o), .mem_o(mem_o),
        .bm_data_i(bm_data_i), .mem_rdata(mem_rdata));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    always @(negedge clk_sys) begin
        if (mem_o.req === 1'b1) begin
            got_w = mem_o.wdata;
            got_a = mem_o.addr;
            got_pm = mem_o.pm;
        end
        if (byte_dma_engine_irq_r === 1'b1) nirq++;
        if (core_restart_r === 1'b1) nrst++;
        if (bm_o.rd_n === 1'b0 && bm_o.bms_n === 1'b0) bms_low = 1;
        if (bm_o.wr_n === 1'b0) begin
            got_b = {got_b[7:0], bm_o.wdata};
            got_e = {bm_o.page, bm_o.addr};
        end
    end

    // hang guard: the whole run needs well under 3000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [23:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic summarize();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic wr(input logic [13:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask : wr

    task automatic rd(input logic [13:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 0;
        d = reg_rdata_r;
    endtask : rd

    // strobe held past the synchroniser and the access, then released
    task automatic hp(input int k, input logic [15:0] d, output logic [16:0] r);
        while (ack_n !== 1'b0) @(negedge clk_sys);
        hbus = d;
        {hsel_n, hal, hwr_n, hrd_n} = {1'b0, k != 0, k != 1, k != 2};
        repeat (6) @(negedge clk_sys);
        r = {hoe, hout};
        {hsel_n, hal, hwr_n, hrd_n} = 4'hF;
        @(negedge clk_sys);
    endtask : hp

    task automatic go(input logic [3:0] c, input logic [15:0] o, p);
        nirq = 0;
        wr(A_BCTL, {12'h000, c});
        wr(A_BYTE_EXTERNAL_START_OFFSET, o);
        wr(A_BPAGE, p);
        wr(A_BCNT, 16'h0001);
    endtask : go

    task automatic wait_irq(input int n);
        for (int i = 0; i < n && nirq == 0; i++) @(negedge clk_sys);
        repeat (3) @(negedge clk_sys);
    endtask : wait_irq

    initial begin
        repeat (6) @(negedge clk_sys);
        arst_n = 1;
        @(negedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            go({2'h0, i[1:0]}, 16'h0010, 16'h0000);
            wait_irq(100);
            chk("word", exp_w[i], got_w);
            chk("pm", {23'h0, i == 0}, {23'h0, got_pm});
            chk("irqs", 24'h1, nirq[23:0]);
            rd(A_BCNT, v);
            chk("count", 24'h0, {8'h00, v});
        end
        chk("bms_on", 24'h1, {23'h0, bms_low});
        nirq = 0;
        wr(A_BCNT, 16'h0000);
        repeat (30) @(negedge clk_sys);
        chk("zero_cnt", 24'h0, nirq[23:0]);
        wr(A_SYSCTL, 16'h0008);
        bms_low = 0;
        core_ext_req = 1;
        go(4'h1, 16'h3FFF, 16'h0005);
        repeat (10) @(negedge clk_sys);
        chk("held", 24'h1, {23'h0, bm_o.rd_n});
        core_ext_req = 0;
        wait_irq(100);
        chk("carry", 24'h00FA06, got_w);
        chk("bms_off", 24'h0, {23'h0, bms_low});
        wr(A_INTERNAL_START_ADDRESS, 16'h0123);
        host_mem_mode = 1;
        go(4'h5, 16'h02A4, 16'h0007);
        wait_irq(100);
        chk("out_bytes", 24'h000123, {8'h00, got_b});
        chk("out_addr", 24'h000001, {2'h0, got_e});
        host_mem_mode = 0;
        rd(14'h3FE9, v);
        chk("unmapped", 24'h0, {8'h00, v});
        arst_n = 0;
        boot_sel_cfg = 0;
        nirq = 0;
        nrst = 0;
        repeat (6) @(negedge clk_sys);
        arst_n = 1;
        repeat (4) @(negedge clk_sys);
        chk("halt", 24'h1, {23'h0, core_halt_r});
        wait_irq(2500);
        chk("boot_word", 24'h5D5E5F, got_w);
        chk("boot_addr", 24'h00001F, {10'h000, got_a});
        chk("restart", 24'h1, nrst[23:0]);
        arst_n = 0;
        dma_sel_cfg = 1;
        boot_sel_cfg = 1;
        repeat (6) @(negedge clk_sys);
        arst_n = 1;
        repeat (2) @(negedge clk_sys);
        chk("ack_idle", 24'h0, {23'h0, ack_n});
        hp(0, 16'h4100, hr);
        hp(1, 16'hBEEF, hr);
        chk("hp_wr", 24'h00BEEF, got_w);
        chk("hp_wa", 24'h000100, {10'h000, got_a});
        hp(2, 16'h0000, hr);
        chk("hp_rd", 24'h010101, {7'h00, hr});
        hp(0, 16'h8055, hr);
        rd(A_HP_OVL, v);
        chk("hp_ovl", 24'h000055, {8'h00, v});
        hp(0, 16'h7FE5, hr);
        got_w = 24'hFFFFFF;
        hp(1, 16'h1111, hr);
        chk("hp_ctl", 24'hFFFFFF, got_w);
        hp(0, 16'h0200, hr);
        hp(1, 16'h1234, hr);
        hp(1, 16'h0056, hr);
        chk("hp_pm", 24'h123456, got_w);
        hp(2, 16'h0000, hr);
        hp(2, 16'h0000, hr2);
        chk("hp_pmrd", 24'h020001, {hr[7:0], hr2[15:0]});
        summarize();
    end
endmodule : tb_odp_top
